// File: core/fwpe_pkg.sv
`default_nettype none
package fwpe_pkg;
   // core clock and self-timed cycle lengths
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned PROGRAM_CYCLE_TIME_US = 250;
   localparam int unsigned SECTOR_ERASE_TIME_US = 25000;
   localparam int unsigned BLOCK32_ERASE_TIME_US = 80000;
   localparam int unsigned BLOCK64_ERASE_TIME_US = 120000;
   localparam int unsigned PROGRAM_CYCLES = PROGRAM_CYCLE_TIME_US * CLK_MHZ;
   localparam int unsigned SECTOR_CYCLES = SECTOR_ERASE_TIME_US * CLK_MHZ;
   localparam int unsigned BLOCK32_CYCLES = BLOCK32_ERASE_TIME_US * CLK_MHZ;
   localparam int unsigned BLOCK64_CYCLES = BLOCK64_ERASE_TIME_US * CLK_MHZ;

   // opcodes handled here
   localparam logic [7:0] OP_WRAP = 8'h77;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_PROG4 = 8'h12;
   localparam logic [7:0] OP_QPROG = 8'h32;
   localparam logic [7:0] OP_SECT = 8'h20;
   localparam logic [7:0] OP_SECT4 = 8'h21;
   localparam logic [7:0] OP_BLK32 = 8'h52;
   localparam logic [7:0] OP_BLK64 = 8'hd8;

   // region sizes as powers of two
   localparam int PAGE_LOG2 = 8;
   localparam int SECTOR_LOG2 = 12;
   localparam int BLK32_LOG2 = 15;
   localparam int BLK64_LOG2 = 16;

   // wrap byte fields and reset values
   localparam int WRAP_DIS_BIT = 4;
   localparam int WRAP_LEN_LSB = 5;
   localparam logic WRAP_DISABLE_RST = 1'b1;
   localparam logic [1:0] WRAP_LEN_RST = 2'h0;
   localparam logic [6:0] WRAP_MIN_BYTES = 7'h08;

   localparam logic [10:0] ADDR3 = 11'h003;
   localparam logic [10:0] ADDR4 = 11'h004;
   localparam logic [10:0] NBYTES_MAX = 11'h7ff;
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   typedef struct packed {
      logic protect_complement;
      logic protect_granularity;
      logic protect_top_bottom;
      logic [2:0] protect_level;
   } fwpe_prot_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [31:0] addr;
      logic [10:0] nbytes;
      logic [2:0] bitpos;
      logic [7:0] last_byte;
   } fwpe_frame_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CHECK = 3'b001,
      ST_WALK = 3'b011,
      ST_WAIT = 3'b010,
      ST_DONE = 3'b110
   } fwpe_state_t;

   function automatic logic [10:0] addr_bytes(input logic [7:0] op,
                                              input logic addr4);
      if (op == OP_PROG4 || op == OP_SECT4) return ADDR4;
      if (op == OP_WRAP) return ADDR3;
      return addr4 ? ADDR4 : ADDR3;
   endfunction

   function automatic logic is_program(input logic [7:0] op);
      return op == OP_PROG || op == OP_PROG4 || op == OP_QPROG;
   endfunction

   function automatic logic is_erase(input logic [7:0] op);
      return op == OP_SECT || op == OP_SECT4 || op == OP_BLK32 ||
             op == OP_BLK64;
   endfunction
endpackage
`default_nettype wire

// File: core/fwpe_array.sv
`timescale 1ns/1ns
`default_nettype none
module fwpe_array #(
   parameter int AW = 17
) (
   input wire logic clk_in,
   input wire logic ce_in,
   input wire logic we_in,
   input wire logic [AW-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out
);
   logic [7:0] mem_q [0:(1<<AW)-1];

   // single port, registered read of the old contents
   always_ff @(posedge clk_in) begin
      if (ce_in) begin
         if (we_in) begin
            mem_q[addr_in] <= wdata_in;
         end
         rdata_out <= mem_q[addr_in];
      end
   end
endmodule
`default_nettype wire

// File: core/fwpe_page_buf.sv
`timescale 1ns/1ns
`default_nettype none
module fwpe_page_buf #(
   parameter int DW = 8,
   parameter int AW = 8
) (
   input wire logic wr_clk_in,
   input wire logic we_in,
   input wire logic [AW-1:0] waddr_in,
   input wire logic [DW-1:0] wdata_in,
   input wire logic rd_clk_in,
   input wire logic re_in,
   input wire logic [AW-1:0] raddr_in,
   output logic [DW-1:0] rdata_out
);
   logic [DW-1:0] mem_q [0:(1<<AW)-1];

   // written on the link clock; read only once the frame is over
   always_ff @(posedge wr_clk_in) begin
      if (we_in) begin
         mem_q[waddr_in] <= wdata_in;
      end
   end

   always_ff @(posedge rd_clk_in) begin
      if (re_in) begin
         rdata_out <= mem_q[raddr_in];
      end
   end
endmodule
`default_nettype wire

// File: core/fwpe_top.sv
// Behaviour
// - wrap command is 77h, 24 dummy bits, then one wrap byte latched
// - only wrap byte bits six to four matter
// - wrap length select gives 8, 16, 32 or 64 bytes within a page
// - wrap disable low makes quad reads wrap; high means no wrap
// - wrap disable returns to one on every reset
// - page program 02h: opcode, 24/32-bit address, one or more bytes
// - program and erase need the write enable latch set
// - program address wraps within the page; extra bytes overwrite
// - bytes of the page not sent stay unchanged
// - chip select must rise on a byte boundary or command is dropped
// - busy is high for the self-timed cycle and low after it
// - write enable latch clears when a program cycle completes
// - protected regions are neither programmed nor erased
// - program 12h always takes a 32-bit address
// - sector erase 21h always takes a 32-bit address
// - quad program 32h needs quad enable; address and data on four lines
// - sector erase 20h sets the 4 KB sector to FFh
// - block erase 52h sets the 32 KB block to FFh
// - block erase D8h sets the 64 KB block to FFh
// - write enable latch clears when an erase cycle finishes
// - quad reads allowed only while quad enable is set
`timescale 1ns/1ns
`default_nettype none
module fwpe_top #(
   parameter int AW = 17,
   parameter int unsigned PROG_CYCLES = fwpe_pkg::PROGRAM_CYCLES,
   parameter int unsigned SECT_CYCLES = fwpe_pkg::SECTOR_CYCLES,
   parameter int unsigned BLK32_CYCLES = fwpe_pkg::BLOCK32_CYCLES,
   parameter int unsigned BLK64_CYCLES = fwpe_pkg::BLOCK64_CYCLES
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic ce_in,
   input wire logic link_sclk_in,
   input wire logic cs_n_in,
   input wire logic [3:0] io_in,
   input wire logic wel_set_in,
   input wire logic sw_reset_in,
   input wire logic quad_enable_in,
   input wire logic addr4_mode_in,
   input wire fwpe_pkg::fwpe_prot_t protect_in,
   input wire logic [AW-1:0] rd_addr_in,
   output logic [7:0] rd_data_out,
   output logic busy_out,
   output logic write_enable_latch_out,
   output logic wrap_disable_out,
   output logic [1:0] wrap_length_sel_out,
   output logic [6:0] wrap_bytes_out,
   output logic quad_read_ok_out,
   output logic cmd_done_out,
   output logic cmd_reject_out
);
   import fwpe_pkg::*;

   if (AW < BLK64_LOG2 || AW > 32) begin : g_bad_aw
      $error("AW must lie between 16 and 32");
   end
   if (PROG_CYCLES < 1 || SECT_CYCLES < 1 || BLK32_CYCLES < 1 ||
       BLK64_CYCLES < 1) begin : g_bad_cyc
      $error("cycle counts must be at least one");
   end

   function automatic int region_log2(input logic [7:0] op);
      if (op == OP_SECT || op == OP_SECT4) return SECTOR_LOG2;
      if (op == OP_BLK32) return BLK32_LOG2;
      if (op == OP_BLK64) return BLK64_LOG2;
      return PAGE_LOG2;
   endfunction

   function automatic logic [31:0] op_cycles(input logic [7:0] op);
      if (op == OP_SECT || op == OP_SECT4) return 32'(SECT_CYCLES);
      if (op == OP_BLK32) return 32'(BLK32_CYCLES);
      if (op == OP_BLK64) return 32'(BLK64_CYCLES);
      return 32'(PROG_CYCLES);
   endfunction

   // protected when within the top or bottom span, then complemented
   function automatic logic is_prot(input logic [AW-1:0] a,
                                    input fwpe_prot_t p);
      logic [AW-1:0] off;
      int lg;
      logic hit;
      off = p.protect_top_bottom ? a : ~a;
      lg = 0;
      hit = 1'b0;
      if (p.protect_level == 3'h7) begin
         hit = 1'b1;
      end else if (p.protect_level != 3'h0) begin
         if (p.protect_granularity) begin
            lg = SECTOR_LOG2 + int'(p.protect_level) - 1;
            if (lg > BLK32_LOG2) lg = BLK32_LOG2;
         end else begin
            lg = BLK64_LOG2 + int'(p.protect_level) - 1;
         end
         hit = (off >> lg) == '0;
      end
      return hit ^ p.protect_complement;
   endfunction

   // ---------------- link domain ----------------
   logic armed_q;
   logic a4_s1_q, a4_s2_q, bz_s1_q, bz_s2_q;
   logic op_done_q, frame_tog_q;
   logic [6:0] shift_q;
   logic [255:0] mask_q;
   fwpe_frame_t frame_q;
   logic quad_phase, byte_end, buf_we;
   logic [7:0] nxt_byte, data_idx, buf_waddr;
   logic [10:0] link_ab;

   // preset while chip select is high; marks the first edge of a frame.
   // reset presets it too: chip select may show no rising edge before use
   always_ff @(posedge link_sclk_in or posedge cs_n_in or
               posedge srst_in) begin
      if (cs_n_in || srst_in) begin
         armed_q <= 1'b1;
      end else begin
         armed_q <= 1'b0;
      end
   end

   // config levels settle in the first two edges, long before the address
   always_ff @(posedge link_sclk_in or posedge srst_in) begin
      if (srst_in) begin
         a4_s1_q <= 1'b0;
         a4_s2_q <= 1'b0;
         bz_s1_q <= 1'b0;
         bz_s2_q <= 1'b0;
      end else begin
         a4_s1_q <= addr4_mode_in;
         a4_s2_q <= a4_s1_q;
         bz_s1_q <= busy_out;
         bz_s2_q <= bz_s1_q;
      end
   end

   assign quad_phase = op_done_q && frame_q.opcode == OP_QPROG;
   assign nxt_byte = quad_phase ? {shift_q[3:0], io_in}
                                : {shift_q[6:0], io_in[0]};
   assign byte_end = quad_phase ? frame_q.bitpos == 3'h4
                                : frame_q.bitpos == 3'h7;
   assign link_ab = addr_bytes(frame_q.opcode, a4_s2_q);
   assign data_idx = 8'(frame_q.nbytes - link_ab);
   assign buf_waddr = 8'(frame_q.addr[7:0] + data_idx);
   // busy keeps a program frame out of the page buffer, but its first edge still clears mask_q
   assign buf_we = !armed_q && op_done_q && byte_end && !bz_s2_q &&
                   is_program(frame_q.opcode) && frame_q.nbytes >= link_ab;

   // frame capture; results stay put after the last edge for the core
   always_ff @(posedge link_sclk_in or posedge srst_in) begin
      if (srst_in) begin
         frame_q <= '0;
         shift_q <= 7'h00;
         op_done_q <= 1'b0;
         frame_tog_q <= 1'b0;
      end else if (armed_q) begin
         frame_q.bitpos <= 3'h1;
         frame_q.nbytes <= 11'h000;
         frame_q.addr <= 32'h0000_0000;
         shift_q <= {6'h00, io_in[0]};
         op_done_q <= 1'b0;
         frame_tog_q <= ~frame_tog_q;
      end else begin
         frame_q.bitpos <= frame_q.bitpos + (quad_phase ? 3'h4 : 3'h1);
         shift_q <= nxt_byte[6:0];
         if (byte_end && !op_done_q) begin
            frame_q.opcode <= nxt_byte;
            op_done_q <= 1'b1;
         end else if (byte_end) begin
            frame_q.last_byte <= nxt_byte;
            if (frame_q.nbytes != NBYTES_MAX) begin
               frame_q.nbytes <= frame_q.nbytes + 11'h001;
            end
            if (frame_q.nbytes < link_ab) begin
               frame_q.addr <= {frame_q.addr[23:0], nxt_byte};
            end
         end
      end
   end

   // which page bytes this frame carried
   always_ff @(posedge link_sclk_in or posedge srst_in) begin
      if (srst_in) begin
         mask_q <= '0;
      end else if (armed_q) begin
         mask_q <= '0;
      end else if (buf_we) begin
         mask_q[buf_waddr] <= 1'b1;
      end
   end

   // ---------------- core domain ----------------
   fwpe_state_t state_q;
   logic cs_s1_q, cs_s2_q, cs_s3_q, tog_s1_q, tog_s2_q, tog_seen_q;
   logic new_frame, chk_aligned, chk_pe, chk_cnt_ok, chk_prot;
   logic chk_go, chk_wrap, erase_q, phase_q, arr_we;
   logic [10:0] chk_ab;
   logic [AW-1:0] chk_rmask, chk_base, base_q, rmask_q, walk_q, arr_addr;
   logic [7:0] arr_rdata, arr_wdata, buf_rdata;
   logic [31:0] timer_q;
   logic busy_q;

   // chip select and frame toggle enter through two flip-flops
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         tog_s1_q <= 1'b0;
         tog_s2_q <= 1'b0;
         tog_seen_q <= 1'b0;
      end else if (ce_in) begin
         cs_s1_q <= cs_n_in;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         tog_s1_q <= frame_tog_q;
         tog_s2_q <= tog_s1_q;
         if (cs_s2_q && !cs_s3_q) begin
            tog_seen_q <= tog_s2_q;
         end
      end
   end

   assign new_frame = cs_s2_q && !cs_s3_q && tog_s2_q != tog_seen_q;

   // frame decode; link registers are static once chip select is high
   assign chk_ab = addr_bytes(frame_q.opcode, addr4_mode_in);
   assign chk_aligned = op_done_q && frame_q.bitpos == 3'h0;
   assign chk_pe = is_program(frame_q.opcode) || is_erase(frame_q.opcode);
   assign chk_cnt_ok = is_program(frame_q.opcode) ?
                       frame_q.nbytes > chk_ab :
                       frame_q.nbytes == chk_ab;
   assign chk_rmask = AW'((33'h1 << region_log2(frame_q.opcode)) - 33'h1);
   assign chk_base = frame_q.addr[AW-1:0] & ~chk_rmask;
   assign chk_prot = is_prot(chk_base, protect_in) ||
                     is_prot(chk_base | chk_rmask, protect_in);
   assign chk_go = chk_pe && write_enable_latch_out && chk_aligned &&
                   chk_cnt_ok && !chk_prot &&
                   (frame_q.opcode != OP_QPROG || quad_enable_in);
   assign chk_wrap = frame_q.opcode == OP_WRAP && chk_aligned &&
                     frame_q.nbytes == chk_ab + 11'h001;

   // sequencer: check, walk the region, then wait out the cycle time
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         state_q <= ST_IDLE;
         base_q <= '0;
         rmask_q <= '0;
         walk_q <= '0;
         erase_q <= 1'b0;
         phase_q <= 1'b0;
      end else if (ce_in) begin
         case (state_q)
            ST_IDLE: begin
               if (new_frame) state_q <= ST_CHECK;
            end
            ST_CHECK: begin
               state_q <= chk_go ? ST_WALK : ST_IDLE;
               base_q <= chk_base;
               rmask_q <= chk_rmask;
               erase_q <= is_erase(frame_q.opcode);
               walk_q <= '0;
               phase_q <= 1'b0;
            end
            ST_WALK: begin
               phase_q <= ~phase_q;
               if (erase_q || phase_q) begin
                  walk_q <= walk_q + 1'b1;
                  if (walk_q == rmask_q) state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (timer_q == 32'h0000_0000) state_q <= ST_DONE;
            end
            ST_DONE: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // cycle timer runs alongside the walk; busy lasts the longer of both
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         timer_q <= 32'h0000_0000;
      end else if (ce_in) begin
         if (state_q == ST_CHECK && chk_go) begin
            timer_q <= op_cycles(frame_q.opcode) - 32'h0000_0001;
         end else if (timer_q != 32'h0000_0000) begin
            timer_q <= timer_q - 32'h0000_0001;
         end
      end
   end

   // program is read-modify-write in two steps; erase writes each cycle
   assign arr_we = state_q == ST_WALK && (erase_q || phase_q);
   assign arr_addr = state_q == ST_WALK ? (base_q | walk_q) : rd_addr_in;
   assign arr_wdata = erase_q ? ERASED_BYTE :
                      arr_rdata & (mask_q[walk_q[7:0]] ? buf_rdata
                                                       : ERASED_BYTE);

   fwpe_page_buf #(.DW(8), .AW(PAGE_LOG2)) u_page (
      .wr_clk_in(link_sclk_in),
      .we_in(buf_we),
      .waddr_in(buf_waddr),
      .wdata_in(nxt_byte),
      .rd_clk_in(clk_in),
      .re_in(ce_in && state_q == ST_WALK && !phase_q),
      .raddr_in(walk_q[7:0]),
      .rdata_out(buf_rdata)
   );

   fwpe_array #(.AW(AW)) u_array (
      .clk_in(clk_in),
      .ce_in(ce_in),
      .we_in(arr_we),
      .addr_in(arr_addr),
      .wdata_in(arr_wdata),
      .rdata_out(arr_rdata)
   );

   assign rd_data_out = arr_rdata;

   // status: busy, write enable latch and one-cycle result pulses
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         busy_q <= 1'b0;
         write_enable_latch_out <= 1'b0;
         cmd_done_out <= 1'b0;
         cmd_reject_out <= 1'b0;
      end else if (ce_in) begin
         cmd_done_out <= state_q == ST_DONE;
         cmd_reject_out <= state_q == ST_CHECK && !chk_go && !chk_wrap &&
                           (chk_pe || frame_q.opcode == OP_WRAP);
         if (state_q == ST_CHECK && chk_go) busy_q <= 1'b1;
         if (state_q == ST_DONE) begin
            busy_q <= 1'b0;
            write_enable_latch_out <= 1'b0;
         end
         // a set in the same cycle as the clear wins
         if (wel_set_in) write_enable_latch_out <= 1'b1;
      end
   end

   assign busy_out = busy_q;

   // wrap setting; the read path only looks at these outputs
   always_ff @(posedge clk_in) begin
      if (srst_in || sw_reset_in) begin
         wrap_disable_out <= WRAP_DISABLE_RST;
         wrap_length_sel_out <= WRAP_LEN_RST;
         wrap_bytes_out <= 7'h00;
         quad_read_ok_out <= 1'b0;
      end else if (ce_in) begin
         quad_read_ok_out <= quad_enable_in;
         if (state_q == ST_CHECK && chk_wrap) begin
            wrap_disable_out <= frame_q.last_byte[WRAP_DIS_BIT];
            wrap_length_sel_out <= frame_q.last_byte[WRAP_LEN_LSB+:2];
            wrap_bytes_out <= frame_q.last_byte[WRAP_DIS_BIT] ? 7'h00 :
               WRAP_MIN_BYTES << frame_q.last_byte[WRAP_LEN_LSB+:2];
         end
      end
   end

   property p_wrap_rst;
      @(posedge clk_in) srst_in |=> wrap_disable_out && wrap_bytes_out == 7'h00;
   endproperty
   a_wrap_rst: assert property (p_wrap_rst) else $error("wrap not reset");

   property p_wrap_latch;
      @(posedge clk_in) disable iff (srst_in)
      state_q == ST_CHECK && chk_wrap && ce_in && !sw_reset_in |=>
         wrap_disable_out == $past(frame_q.last_byte[4]) &&
         wrap_length_sel_out == $past(frame_q.last_byte[6:5]);
   endproperty
   a_wrap_latch: assert property (p_wrap_latch) else $error("wrap byte lost");

   property p_wrap_len;
      @(posedge clk_in) disable iff (srst_in)
      !wrap_disable_out && $changed(wrap_length_sel_out) |->
         wrap_bytes_out == (7'h08 << wrap_length_sel_out);
   endproperty
   a_wrap_len: assert property (p_wrap_len) else $error("wrap length bad");

   property p_no_wel;
      @(posedge clk_in) disable iff (srst_in)
      state_q == ST_CHECK && ce_in && chk_pe && !write_enable_latch_out |=>
         !busy_out && cmd_reject_out;
   endproperty
   a_no_wel: assert property (p_no_wel) else $error("ran without latch");

   property p_frame;
      @(posedge clk_in) disable iff (srst_in)
      state_q == ST_CHECK && ce_in && chk_pe && !chk_aligned |=>
         cmd_reject_out && state_q == ST_IDLE;
   endproperty
   a_frame: assert property (p_frame) else $error("odd frame executed");

   property p_qe;
      @(posedge clk_in) disable iff (srst_in)
      state_q == ST_CHECK && ce_in && frame_q.opcode == OP_QPROG &&
      !quad_enable_in |=> !busy_out;
   endproperty
   a_qe: assert property (p_qe) else $error("quad program without enable");

   property p_prot;
      @(posedge clk_in) disable iff (srst_in)
      state_q == ST_CHECK && ce_in && chk_prot |=> !busy_out ##1 !busy_out;
   endproperty
   a_prot: assert property (p_prot) else $error("protected area touched");

   property p_busy_end;
      @(posedge clk_in) disable iff (srst_in)
      $fell(busy_out) |-> cmd_done_out && $past(state_q) == ST_DONE;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy ended early");

   property p_wel_prog;
      @(posedge clk_in) disable iff (srst_in)
      cmd_done_out && !erase_q |-> !write_enable_latch_out || $past(wel_set_in);
   endproperty
   a_wel_prog: assert property (p_wel_prog) else $error("latch kept");

   property p_wel_erase;
      @(posedge clk_in) disable iff (srst_in)
      cmd_done_out && erase_q |-> !write_enable_latch_out || $past(wel_set_in);
   endproperty
   a_wel_erase: assert property (p_wel_erase) else $error("latch kept");

   property p_erase_ff;
      @(posedge clk_in) disable iff (srst_in)
      arr_we && erase_q |-> arr_wdata == 8'hff;
   endproperty
   a_erase_ff: assert property (p_erase_ff) else $error("erase not ff");

   property p_prog_and;
      @(posedge clk_in) disable iff (srst_in)
      arr_we && !erase_q |-> (arr_wdata & ~arr_rdata) == 8'h00;
   endproperty
   a_prog_and: assert property (p_prog_and) else $error("bit set by program");

   c_prog: cover property (@(posedge clk_in) cmd_done_out && !erase_q);
   c_erase: cover property (@(posedge clk_in) cmd_done_out && erase_q);
   c_wrap: cover property (@(posedge clk_in) $fell(wrap_disable_out));
   c_reject: cover property (@(posedge clk_in) cmd_reject_out);
endmodule
`default_nettype wire

// File: testbench/fwpe_host.sv
`timescale 1ns/1ns
`default_nettype none
module fwpe_host (
   output logic cs_n_out,
   output logic sclk_out,
   output logic [3:0] io_out
);
   // deselected, sclk resting low
   initial {cs_n_out, sclk_out, io_out} = 6'h20;
   // mode 0, msb first, 64 ns sclk; after ser bits on io0 the rest go
   // four at a time, io3 first; cs_n up after the last bit
   task automatic send(input logic [63:0] v, input int n,
                       input int ser = 64);
      int i;
      i = n - 1;
      cs_n_out = 1'b0;
      while (i >= 0) begin
         if (n - 1 - i < ser) begin
            io_out = {3'h0, v[i]};
            i = i - 1;
         end else begin
            io_out = v[i-:4];
            i = i - 4;
         end
         #32 sclk_out = 1'b1;
         #32 sclk_out = 1'b0;
      end
      #32 cs_n_out = 1'b1;
      io_out = ~io_out; // released line must not keep the last bit
   endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   import fwpe_pkg::*;
   logic clk_in = 1'b0, srst_in = 1'b0, write_enable_latch = 1'b0, swr = 1'b0, qe = 1'b0;
   logic a4 = 1'b0;
   fwpe_prot_t prot = '0;
   logic [16:0] ra = '0;
   logic cs_n, sclk, busy, latch, wdis, qok, done, rej;
   logic [3:0] io;
   logic [1:0] wlen;
   logic [6:0] wb;
   logic [7:0] rd;
   int errors = 0, checks = 0;
   always #4 clk_in = ~clk_in;
   fwpe_host host (.cs_n_out(cs_n), .sclk_out(sclk), .io_out(io));
   // short self-timed counts; the walks then set the busy length
   fwpe_top #(.PROG_CYCLES(20), .SECT_CYCLES(20), .BLK32_CYCLES(20),
      .BLK64_CYCLES(20)) dut (.clk_in(clk_in), .srst_in(srst_in),
      .ce_in(1'b1), .link_sclk_in(sclk), .cs_n_in(cs_n), .io_in(io),
      .wel_set_in(write_enable_latch), .sw_reset_in(swr), .quad_enable_in(qe),
      .addr4_mode_in(a4), .protect_in(prot), .rd_addr_in(ra),
      .rd_data_out(rd), .busy_out(busy), .write_enable_latch_out(latch),
      .wrap_disable_out(wdis), .wrap_length_sel_out(wlen),
      .wrap_bytes_out(wb), .quad_read_ok_out(qok),
      .cmd_done_out(done), .cmd_reject_out(rej));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic tick();
      @(posedge clk_in);
      #1;
   endtask
   // one frame, then a bounded wait for the done or reject pulse
   task automatic frame(input logic [63:0] v, input int n, input logic ok,
                        input int ser = 64);
      logic seen;
      seen = 1'b0;
      host.send(v, n, ser);
      for (int i = 0; i < 40000 && !(done | rej); i++) begin
         tick();
         seen |= busy;
      end
      check({busy, seen, done, rej}, {1'b0, ok, ok, !ok});
      if (ok) check(latch, 1'b0);
      repeat (8) tick();
   endtask
   task automatic wen();
      write_enable_latch = 1'b1;
      tick();
      write_enable_latch = 1'b0;
      check(latch, 1'b1);
   endtask
   task automatic rdchk(input logic [16:0] a, input logic [7:0] exp);
      ra = a;
      tick();
      check(rd, exp);
   endtask
   // main sequence
   initial begin
      // raised off time zero so the link flops see a reset edge
      #1 srst_in = 1'b1;
      repeat (8) tick();
      srst_in = 1'b0;
      check({busy, latch, wdis, wb}, {3'b001, 7'h00});
      repeat (3) tick();
      // unused wrap bits set high to show they are ignored
      for (int l = 0; l < 4; l++) begin
         host.send({8'h77, 24'h0, 1'b1, 2'(l), 5'h0f}, 40);
         repeat (8) tick();
         check({wdis, wlen, wb},
               {1'b0, 2'(l), 7'(8 << l)});
      end
      swr = 1'b1;
      tick();
      swr = 1'b0;
      qe = 1'b1;
      repeat (2) tick();
      check({wdis, wb, qok}, {1'b1, 7'h00, 1'b1});
      frame({8'h20, 24'h000100}, 32, 1'b0);
      wen();
      frame({8'h20, 24'h000100}, 32, 1'b1);
      rdchk(17'h00fff, 8'hff);
      wen();
      frame({8'h02, 24'h0001fe, 24'ha53c0f}, 56, 1'b1);
      rdchk(17'h001fe, 8'ha5);
      rdchk(17'h001ff, 8'h3c);
      rdchk(17'h00100, 8'h0f);
      rdchk(17'h00101, 8'hff);
      wen();
      frame({8'h12, 32'h00000100, 8'hf0}, 48, 1'b1);
      rdchk(17'h00100, 8'h00);
      // quad program: refused without quad enable, then accepted
      qe = 1'b0;
      wen();
      frame({8'h32, 24'h000200, 8'h5a}, 40, 1'b0, 8);
      check(qok, 1'b0);
      qe = 1'b1;
      frame({8'h32, 24'h000200, 8'h5a}, 40, 1'b1, 8);
      rdchk(17'h00200, 8'h5a);
      // four-byte address mode on the plain program command
      a4 = 1'b1;
      wen();
      frame({8'h02, 32'h00000300, 8'hc3}, 48, 1'b1);
      a4 = 1'b0;
      rdchk(17'h00300, 8'hc3);
      wen();
      frame({8'h02, 24'h000100, 11'h0}, 43, 1'b0);
      prot.protect_level = 3'h7;
      frame({8'h21, 32'h00001000}, 40, 1'b0);
      prot.protect_level = 3'h0;
      frame({8'h21, 32'h00001000}, 40, 1'b1);
      wen();
      frame({8'h52, 24'h000000}, 32, 1'b1);
      rdchk(17'h00100, 8'hff);
      report_and_stop();
   end
   // watchdog, well past the longest erase walk
   initial begin
      #800000;
      errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
